// File: core/cbse_defines.svh
// constants for the branch, bit-set and shift execution block
// assumes inclusion by bare name from every core file
`ifndef CBSE_DEFINES_SVH
`define CBSE_DEFINES_SVH
// status flag positions
`define SREG_C 0
`define SREG_Z 1
`define SREG_N 2
`define SREG_V 3
`define SREG_H 5
`define SREG_I 7
// widths
`define PC_W 16
`define REG_W 8
`define REG_MSB 7
`define K_W 7
`define K_MSB 6
`define K_EXT 9
`define IO_AW 5
`define IO_N 32
`define BIT_W 3
`define ADDR_W 6
// reset values and constants
`define PC_RST 16'h0000
`define PC_ONE 16'h0001
`define BYTE_ZERO 8'h00
// register port map
`define A_SREG 6'h00
`define A_WREG 6'h01
`define A_PCL 6'h02
`define A_PCH 6'h03
`define A_STAT 6'h04
`define A_IO_BIT 5
`endif

// File: core/cbse_pkg.sv
// types shared by the execution block and its helpers
// assumes nothing beyond the defines header
package cbse_pkg;
  // instruction codes driven by the decoder in front of this block
  typedef enum logic [4:0] {
    OP_NOP                  = 5'h00,
    OP_BRANCH_IF_LOWER      = 5'h01,
    OP_BRANCH_IF_MINUS      = 5'h02,
    OP_BRANCH_IF_PLUS       = 5'h03,
    OP_BRANCH_SIGNED_GE     = 5'h04,
    OP_BRANCH_SIGNED_LT     = 5'h05,
    OP_BRANCH_HALF_CARRY_SET   = 5'h06,
    OP_BRANCH_HALF_CARRY_CLEAR = 5'h07,
    OP_BRANCH_OVERFLOW_CLEAR   = 5'h08,
    OP_BRANCH_IRQ_ENABLED   = 5'h09,
    OP_BRANCH_IRQ_DISABLED  = 5'h0A,
    OP_IO_BIT_SET           = 5'h0B,
    OP_IO_BIT_CLEAR         = 5'h0C,
    OP_SHIFT_LEFT_LOGICAL   = 5'h0D,
    OP_SHIFT_RIGHT_LOGICAL  = 5'h0E,
    OP_ROTATE_LEFT_CARRY    = 5'h0F,
    OP_ROTATE_RIGHT_CARRY   = 5'h10
  } op_t;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_BUBBLE = 2'b01,
    ST_IO_WR  = 2'b10
  } state_t;
endpackage : cbse_pkg

// File: core/exec_if.sv
// operand and result bundle between the core and its two helpers
// assumes all helpers are purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cbse_defines.svh"
interface exec_if;
  import cbse_pkg::*;
  op_t               op;
  logic [`REG_W-1:0] sreg;
  logic [`REG_W-1:0] rd;
  logic [`K_W-1:0]   k;
  logic [`PC_W-1:0]  pc;
  logic              taken;
  logic [`PC_W-1:0]  target;
  logic [`REG_W-1:0] sh_res;
  logic [`REG_W-1:0] sh_sreg;
  modport core    (output op, sreg, rd, k, pc,
                   input taken, target, sh_res, sh_sreg);
  modport branch  (input op, sreg, k, pc, output taken, target);
  modport shifter (input op, sreg, rd, output sh_res, sh_sreg);
endinterface : exec_if
`default_nettype wire

// File: core/branch_eval.sv
// branch condition test and target arithmetic
// assumes pc is the address of the branch itself
`timescale 1ns/1ps
`default_nettype none
`include "cbse_defines.svh"
module branch_eval
  import cbse_pkg::*;
(
  exec_if.branch x  // operands in, decision out
);
  // ==========================================================
  // condition and target
  // ==========================================================
  always_comb
  begin
    // signed word displacement, sign extended
    x.target = x.pc + {{`K_EXT{x.k[`K_MSB]}}, x.k} + `PC_ONE;
    case (x.op)
      OP_BRANCH_IF_LOWER:         x.taken = x.sreg[`SREG_C];
      OP_BRANCH_IF_MINUS:         x.taken = x.sreg[`SREG_N];
      OP_BRANCH_IF_PLUS:          x.taken = ~x.sreg[`SREG_N];
      OP_BRANCH_SIGNED_GE:
        x.taken = ~(x.sreg[`SREG_N] ^ x.sreg[`SREG_V]);
      OP_BRANCH_SIGNED_LT:
        x.taken = x.sreg[`SREG_N] ^ x.sreg[`SREG_V];
      OP_BRANCH_HALF_CARRY_SET:   x.taken = x.sreg[`SREG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: x.taken = ~x.sreg[`SREG_H];
      OP_BRANCH_OVERFLOW_CLEAR:   x.taken = ~x.sreg[`SREG_V];
      OP_BRANCH_IRQ_ENABLED:      x.taken = x.sreg[`SREG_I];
      OP_BRANCH_IRQ_DISABLED:     x.taken = ~x.sreg[`SREG_I];
      default:                    x.taken = 1'b0;
    endcase
  end
endmodule : branch_eval
`default_nettype wire

// File: core/shift_unit.sv
// one-place shifts and rotates through carry with flag update
// assumes rd and sreg are the values before the instruction
`timescale 1ns/1ps
`default_nettype none
`include "cbse_defines.svh"
module shift_unit
  import cbse_pkg::*;
(
  exec_if.shifter x  // operand in, result and flags out
);
  logic cout;
  // ==========================================================
  // result and carry out
  // ==========================================================
  always_comb
  begin
    case (x.op)
      OP_SHIFT_LEFT_LOGICAL:
      begin
        x.sh_res = {x.rd[`REG_MSB-1:0], 1'b0};
        cout     = x.rd[`REG_MSB];
      end
      OP_SHIFT_RIGHT_LOGICAL:
      begin
        x.sh_res = {1'b0, x.rd[`REG_MSB:1]};
        cout     = x.rd[0];
      end
      OP_ROTATE_LEFT_CARRY:
      begin
        x.sh_res = {x.rd[`REG_MSB-1:0], x.sreg[`SREG_C]};
        cout     = x.rd[`REG_MSB];
      end
      OP_ROTATE_RIGHT_CARRY:
      begin
        x.sh_res = {x.sreg[`SREG_C], x.rd[`REG_MSB:1]};
        cout     = x.rd[0];
      end
      default:
      begin
        x.sh_res = x.rd;
        cout     = x.sreg[`SREG_C];
      end
    endcase
  end
  // ==========================================================
  // flags: only z, c, n and v move; v is n xor c
  // ==========================================================
  always_comb
  begin
    x.sh_sreg          = x.sreg;
    x.sh_sreg[`SREG_C] = cout;
    x.sh_sreg[`SREG_Z] = (x.sh_res == `BYTE_ZERO);
    x.sh_sreg[`SREG_N] = x.sh_res[`REG_MSB];
    x.sh_sreg[`SREG_V] = x.sh_res[`REG_MSB] ^ cout;
  end
endmodule : shift_unit
`default_nettype wire

// File: core/cond_branch_shift_exec.sv
// execution block: conditional branches, i/o bit set and clear,
// shifts and rotates of one working register
// assumes a decoder presents one instruction at a time, held with
// instr_valid_i, and takes it only while ready_o is high
//
// How it works
// - carry set: jump pc+k+1, 1/2 cycles
// - negative set: jump pc+k+1, 1/2 cycles
// - negative clear: jump pc+k+1, 1/2 cycles
// - n xor v clear: jump, 1/2 cycles
// - n xor v set: jump, 1/2 cycles
// - half carry set: jump, 1/2 cycles
// - half carry clear: jump, 1/2 cycles
// - overflow clear: jump, 1/2 cycles
// - interrupts enabled: jump, 1/2 cycles
// - interrupts disabled: jump, 1/2 cycles
// - set one i/o bit, two cycles
// - clear one i/o bit, two cycles
// - shift left, zero in, zcnv, one cycle
// - shift right, zero in, zcnv, one cycle
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
`timescale 1ns/1ps
`default_nettype none
`include "cbse_defines.svh"
module cond_branch_shift_exec
  import cbse_pkg::*;
(
  input  wire logic               sys_clk_i,     // core clock
  input  wire logic               reset_i,       // sync reset, high
  input  wire logic               instr_valid_i, // instruction offered
  input  wire op_t                instr_op_i,    // instruction code
  input  wire logic [`K_W-1:0]    instr_k_i,     // branch offset
  input  wire logic [`IO_AW-1:0]  instr_io_i,    // i/o register index
  input  wire logic [`BIT_W-1:0]  instr_bit_i,   // i/o bit index
  output logic                    ready_o,       // can take an instr
  output logic [`PC_W-1:0]        pc_o,          // program counter
  output logic [`REG_W-1:0]       sreg_o,        // status flags
  output logic [`REG_W-1:0]       wreg_o,        // working register
  input  wire logic [`ADDR_W-1:0] bus_addr_i,    // register address
  input  wire logic [`REG_W-1:0]  bus_wdata_i,   // write data
  input  wire logic               bus_wr_i,      // write strobe
  input  wire logic               bus_rd_i,      // read strobe
  output logic [`REG_W-1:0]       bus_rdata_o    // read data, next cycle
);

  // ==========================================================
  // state
  // ==========================================================
  state_t             state_q;
  state_t             state_d;
  logic               ready_q;
  logic [`PC_W-1:0]   pc_q;
  logic [`REG_W-1:0]  sreg_q;
  logic [`REG_W-1:0]  wreg_q;
  logic [`REG_W-1:0]  rdata_q;
  logic [`IO_AW-1:0]  io_idx_q;
  logic [`BIT_W-1:0]  io_bit_q;
  logic               io_set_q;
  logic [`REG_W-1:0]  io_val_q;
  logic [`REG_W-1:0]  io_mem_q [`IO_N];
  logic [`REG_W-1:0]  io_new;

  // ==========================================================
  // decode of the offered instruction
  // ==========================================================
  logic accept;
  logic is_branch;
  logic is_io;
  logic is_shift;

  // an instruction counts only when the block is ready
  assign accept = instr_valid_i & ready_q;

  // sort the code into its three families
  always_comb
  begin
    is_branch = 1'b0;
    is_io     = 1'b0;
    is_shift  = 1'b0;
    case (instr_op_i)
      OP_BRANCH_IF_LOWER,
      OP_BRANCH_IF_MINUS,
      OP_BRANCH_IF_PLUS,
      OP_BRANCH_SIGNED_GE,
      OP_BRANCH_SIGNED_LT,
      OP_BRANCH_HALF_CARRY_SET,
      OP_BRANCH_HALF_CARRY_CLEAR,
      OP_BRANCH_OVERFLOW_CLEAR,
      OP_BRANCH_IRQ_ENABLED,
      OP_BRANCH_IRQ_DISABLED:
        is_branch = 1'b1;
      OP_IO_BIT_SET,
      OP_IO_BIT_CLEAR:
        is_io = 1'b1;
      OP_SHIFT_LEFT_LOGICAL,
      OP_SHIFT_RIGHT_LOGICAL,
      OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY:
        is_shift = 1'b1;
      default:
      begin
        is_branch = 1'b0;
        is_io     = 1'b0;
        is_shift  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // helpers
  // ==========================================================
  exec_if ex ();

  // helpers always see the current flags and working register
  assign ex.op   = instr_op_i;
  assign ex.sreg = sreg_q;
  assign ex.rd   = wreg_q;
  assign ex.k    = instr_k_i;
  assign ex.pc   = pc_q;

  branch_eval u_branch (
    .x (ex.branch)
  );

  shift_unit u_shift (
    .x (ex.shifter)
  );

  // ==========================================================
  // sequencer
  // ==========================================================
  // the taken branch spends its second cycle as a bubble; the
  // untaken one retires at once, so the cost follows the flag
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept && is_branch && ex.taken)
          state_d = ST_BUBBLE;
        else if (accept && is_io)
          state_d = ST_IO_WR;
        else
          state_d = ST_IDLE;
      end
      ST_BUBBLE: state_d = ST_IDLE;
      ST_IO_WR:  state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // ready is registered so the decoder sees a clean level
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      ready_q <= 1'b1;
    else
      ready_q <= (state_d == ST_IDLE);
  end

  // ==========================================================
  // program counter
  // ==========================================================
  // a port write wins over an instruction in the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      pc_q <= `PC_RST;
    else if (bus_wr_i && bus_addr_i == `A_PCL)
      pc_q <= {pc_q[`PC_W-1:`REG_W], bus_wdata_i};
    else if (bus_wr_i && bus_addr_i == `A_PCH)
      pc_q <= {bus_wdata_i, pc_q[`REG_W-1:0]};
    else if (accept && is_branch && ex.taken)
      pc_q <= ex.target;
    else if (accept)
      pc_q <= pc_q + `PC_ONE;
  end

  // ==========================================================
  // status flags
  // ==========================================================
  // branches and i/o bit ops leave the flags alone
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      sreg_q <= `BYTE_ZERO;
    else if (bus_wr_i && bus_addr_i == `A_SREG)
      sreg_q <= bus_wdata_i;
    else if (accept && is_shift)
      sreg_q <= ex.sh_sreg;
  end

  // ==========================================================
  // working register
  // ==========================================================
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      wreg_q <= `BYTE_ZERO;
    else if (bus_wr_i && bus_addr_i == `A_WREG)
      wreg_q <= bus_wdata_i;
    else if (accept && is_shift)
      wreg_q <= ex.sh_res;
  end

  // ==========================================================
  // i/o bit set and clear: read in cycle one, write in cycle two
  // ==========================================================
  // capture target, bit and old value on the first cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      io_idx_q <= {`IO_AW{1'b0}};
      io_bit_q <= {`BIT_W{1'b0}};
      io_set_q <= 1'b0;
      io_val_q <= `BYTE_ZERO;
    end
    else if (accept && is_io)
    begin
      io_idx_q <= instr_io_i;
      io_bit_q <= instr_bit_i;
      io_set_q <= (instr_op_i == OP_IO_BIT_SET);
      io_val_q <= io_mem_q[instr_io_i];
    end
  end

  // modify only the chosen bit; the rest pass unchanged
  always_comb
  begin
    io_new           = io_val_q;
    io_new[io_bit_q] = io_set_q;
  end

  // one register per entry; a port write to the same entry in
  // the write cycle wins, which can undo the bit operation
  for (genvar g = 0; g < `IO_N; g++)
  begin : g_io
    always_ff @(posedge sys_clk_i)
    begin
      if (reset_i)
        io_mem_q[g] <= `BYTE_ZERO;
      else if (bus_wr_i && bus_addr_i[`A_IO_BIT]
               && bus_addr_i[`IO_AW-1:0] == `IO_AW'(g))
        io_mem_q[g] <= bus_wdata_i;
      else if (state_q == ST_IO_WR && io_idx_q == `IO_AW'(g))
        io_mem_q[g] <= io_new;
    end
  end

  // ==========================================================
  // register port read side
  // ==========================================================
  // data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rdata_q <= `BYTE_ZERO;
    else if (!bus_rd_i)
      rdata_q <= `BYTE_ZERO;
    else if (bus_addr_i[`A_IO_BIT])
      rdata_q <= io_mem_q[bus_addr_i[`IO_AW-1:0]];
    else
    begin
      case (bus_addr_i)
        `A_SREG: rdata_q <= sreg_q;
        `A_WREG: rdata_q <= wreg_q;
        `A_PCL:  rdata_q <= pc_q[`REG_W-1:0];
        `A_PCH:  rdata_q <= pc_q[`PC_W-1:`REG_W];
        `A_STAT: rdata_q <= {{(`REG_W-3){1'b0}}, ~ready_q, state_q};
        default: rdata_q <= `BYTE_ZERO; // unmapped reads zero
      endcase
    end
  end

  // ==========================================================
  // outputs, all straight from flip-flops
  // ==========================================================
  assign ready_o     = ready_q;
  assign pc_o        = pc_q;
  assign sreg_o      = sreg_q;
  assign wreg_o      = wreg_q;
  assign bus_rdata_o = rdata_q;

endmodule : cond_branch_shift_exec
`default_nettype wire

// File: verification/cond_branch_shift_exec_properties.sv
// checker: branch, bit-op and shift relations at the block's ports
// assumes one clock domain and a bind onto the block's top module
`timescale 1ns/1ps
`default_nettype none
`include "cbse_defines.svh"
module cond_branch_shift_exec_properties
  import cbse_pkg::*;
(
  input wire logic               sys_clk_i,     // core clock
  input wire logic               reset_i,       // sync reset, high
  input wire logic               instr_valid_i, // instruction offered
  input wire op_t                instr_op_i,    // instruction code
  input wire logic [`K_W-1:0]    instr_k_i,     // branch offset
  input wire logic               ready_o,       // can take an instr
  input wire logic [`PC_W-1:0]   pc_o,          // program counter
  input wire logic [`REG_W-1:0]  sreg_o,        // status flags
  input wire logic [`REG_W-1:0]  wreg_o,        // working register
  input wire logic               bus_wr_i,      // write strobe
  input wire logic               bus_rd_i,      // read strobe
  input wire logic [`REG_W-1:0]  bus_rdata_o    // read data
);
  // ==========================================================
  // helper logic
  logic [`REG_W-1:0] w_q;   // working register one cycle back
  logic [`REG_W-1:0] s_q;   // flags one cycle back
  logic [`PC_W-1:0]  pc_q;  // pc one cycle back
  logic [`K_W-1:0]   k_q;   // offset one cycle back
  logic              take;  // taken with no bus write racing it
  logic              is_br;
  logic              is_io;
  logic              hit;

  // condition test kept apart from the design's own evaluator
  function automatic logic br_cond(input op_t o, input logic [`REG_W-1:0] s);
    case (o)
      OP_BRANCH_IF_LOWER:         br_cond = s[`SREG_C];
      OP_BRANCH_IF_MINUS:         br_cond = s[`SREG_N];
      OP_BRANCH_IF_PLUS:          br_cond = !s[`SREG_N];
      OP_BRANCH_SIGNED_GE:        br_cond = !(s[`SREG_N] ^ s[`SREG_V]);
      OP_BRANCH_SIGNED_LT:        br_cond = s[`SREG_N] ^ s[`SREG_V];
      OP_BRANCH_HALF_CARRY_SET:   br_cond = s[`SREG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: br_cond = !s[`SREG_H];
      OP_BRANCH_OVERFLOW_CLEAR:   br_cond = !s[`SREG_V];
      OP_BRANCH_IRQ_ENABLED:      br_cond = s[`SREG_I];
      OP_BRANCH_IRQ_DISABLED:     br_cond = !s[`SREG_I];
      default:                    br_cond = 1'b0;
    endcase
  endfunction : br_cond

  // a bus write in the take cycle wins, so those cycles are left out
  assign take  = instr_valid_i && ready_o && !bus_wr_i;
  assign is_br = instr_op_i inside {[OP_BRANCH_IF_LOWER:OP_BRANCH_IRQ_DISABLED]};
  assign is_io = instr_op_i inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
  assign hit   = br_cond(instr_op_i, sreg_o);

  // previous values for result comparisons
  always_ff @(posedge sys_clk_i)
  begin
    w_q  <= wreg_o;
    s_q  <= sreg_o;
    pc_q <= pc_o;
    k_q  <= instr_k_i;
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence bubble_s;
    !ready_o ##1 ready_o;
  endsequence

  branch_target_a: assert property (take && is_br && hit |=>
    pc_o == pc_q + {{`K_EXT{k_q[`K_MSB]}}, k_q} + `PC_ONE) else $error("bad branch target");
  branch_bubble_a: assert property (take && is_br && hit |=> bubble_s)
    else $error("taken branch not two cycles");
  branch_fall_a: assert property (take && is_br && !hit |=>
    ready_o && pc_o == pc_q + `PC_ONE) else $error("bad fall through");
  flags_kept_a: assert property (take && (is_br || is_io) |=> $stable(sreg_o))
    else $error("flags changed");
  io_bubble_a: assert property (take && is_io |=> bubble_s)
    else $error("bit op not two cycles");
  shl_result_a: assert property (take && instr_op_i == OP_SHIFT_LEFT_LOGICAL |=>
    wreg_o == {w_q[6:0], 1'b0} && sreg_o[`SREG_C] == w_q[7]) else $error("bad left shift");
  shr_result_a: assert property (take && instr_op_i == OP_SHIFT_RIGHT_LOGICAL |=>
    wreg_o == {1'b0, w_q[7:1]} && sreg_o[`SREG_C] == w_q[0]) else $error("bad right shift");
  rol_result_a: assert property (take && instr_op_i == OP_ROTATE_LEFT_CARRY |=>
    wreg_o == {w_q[6:0], s_q[0]} && sreg_o[`SREG_C] == w_q[7]) else $error("bad left rotate");
  ror_result_a: assert property (take && instr_op_i == OP_ROTATE_RIGHT_CARRY |=>
    wreg_o == {s_q[0], w_q[7:1]} && sreg_o[`SREG_C] == w_q[0]) else $error("bad right rotate");
  shift_flags_a: assert property (take && instr_op_i inside {[OP_SHIFT_LEFT_LOGICAL:OP_ROTATE_RIGHT_CARRY]} |=>
    sreg_o[`SREG_Z] == (wreg_o == `BYTE_ZERO) && sreg_o[`SREG_N] == wreg_o[7] &&
    sreg_o[`SREG_V] == (wreg_o[7] ^ sreg_o[`SREG_C]) && sreg_o[7:4] == s_q[7:4])
    else $error("bad shift flags");
  reset_state_a: assert property (disable iff (1'b0) reset_i |=>
    ready_o && pc_o == `PC_RST && sreg_o == `BYTE_ZERO) else $error("bad reset state");
  read_idle_a: assert property (!bus_rd_i |=> bus_rdata_o == `BYTE_ZERO)
    else $error("read data outside its cycle");
endmodule : cond_branch_shift_exec_properties

bind cond_branch_shift_exec cond_branch_shift_exec_properties chk_u (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
  .instr_op_i(instr_op_i), .instr_k_i(instr_k_i), .ready_o(ready_o), .pc_o(pc_o),
  .sreg_o(sreg_o), .wreg_o(wreg_o), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_rdata_o(bus_rdata_o));
`default_nettype wire

// File: verification/cond_branch_shift_exec_tb.sv
// testbench: instruction table first, then bit ops, reset and refusals
// assumes the checker file binds itself onto the block
`timescale 1ns/1ps
`default_nettype none
`include "cbse_defines.svh"
module cond_branch_shift_exec_tb;
  import cbse_pkg::*;
  typedef struct {
    logic [4:0]  op;
    logic [7:0]  s;
    logic [7:0]  w;
    logic [6:0]  k;
    logic [15:0] epc;
    logic [7:0]  ew;
    logic [7:0]  es;
    logic        bub;
  } row_t;
  // ==========================================================
  // signals
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        instr_valid = 1'b0;
  op_t         instr_op = OP_NOP;
  logic [6:0]  instr_k = 7'h00;
  logic [4:0]  instr_io = 5'h00;
  logic [2:0]  instr_bit = 3'h0;
  logic [5:0]  bus_addr = 6'h00;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic        ready;
  logic [15:0] pc;
  logic [7:0]  sreg;
  logic [7:0]  wreg;
  logic [7:0]  bus_rdata;
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // every branch taken and not taken from pc 0x0100, then each shift
  row_t rows [24] = '{
    '{5'h01,8'h01,8'h3C,7'h05,16'h0106,8'h3C,8'h01,1'b1}, '{5'h01,8'h00,8'h3C,7'h05,16'h0101,8'h3C,8'h00,1'b0},
    '{5'h02,8'h04,8'h3C,7'h40,16'h00C1,8'h3C,8'h04,1'b1}, '{5'h02,8'h00,8'h3C,7'h40,16'h0101,8'h3C,8'h00,1'b0},
    '{5'h03,8'h00,8'h3C,7'h3F,16'h0140,8'h3C,8'h00,1'b1}, '{5'h03,8'h04,8'h3C,7'h3F,16'h0101,8'h3C,8'h04,1'b0},
    '{5'h04,8'h0C,8'h3C,7'h7F,16'h0100,8'h3C,8'h0C,1'b1}, '{5'h04,8'h04,8'h3C,7'h7F,16'h0101,8'h3C,8'h04,1'b0},
    '{5'h05,8'h08,8'h3C,7'h02,16'h0103,8'h3C,8'h08,1'b1}, '{5'h05,8'h0C,8'h3C,7'h02,16'h0101,8'h3C,8'h0C,1'b0},
    '{5'h06,8'h20,8'h3C,7'h01,16'h0102,8'h3C,8'h20,1'b1}, '{5'h06,8'hDF,8'h3C,7'h01,16'h0101,8'h3C,8'hDF,1'b0},
    '{5'h07,8'h00,8'h3C,7'h10,16'h0111,8'h3C,8'h00,1'b1}, '{5'h07,8'h20,8'h3C,7'h10,16'h0101,8'h3C,8'h20,1'b0},
    '{5'h08,8'h00,8'h3C,7'h7E,16'h00FF,8'h3C,8'h00,1'b1}, '{5'h08,8'h08,8'h3C,7'h7E,16'h0101,8'h3C,8'h08,1'b0},
    '{5'h09,8'h80,8'h3C,7'h04,16'h0105,8'h3C,8'h80,1'b1}, '{5'h09,8'h7F,8'h3C,7'h04,16'h0101,8'h3C,8'h7F,1'b0},
    '{5'h0A,8'h00,8'h3C,7'h20,16'h0121,8'h3C,8'h00,1'b1}, '{5'h0A,8'h80,8'h3C,7'h20,16'h0101,8'h3C,8'h80,1'b0},
    '{5'h0D,8'h00,8'h81,7'h00,16'h0101,8'h02,8'h09,1'b0}, '{5'h0E,8'hF0,8'h01,7'h00,16'h0101,8'h00,8'hFB,1'b0},
    '{5'h0F,8'h01,8'h80,7'h00,16'h0101,8'h01,8'h09,1'b0}, '{5'h10,8'h21,8'h01,7'h00,16'h0101,8'h80,8'h25,1'b0}};

  cond_branch_shift_exec dut_u (
    .sys_clk_i(sys_clk), .reset_i(reset), .instr_valid_i(instr_valid), .instr_op_i(instr_op),
    .instr_k_i(instr_k), .instr_io_i(instr_io), .instr_bit_i(instr_bit), .ready_o(ready),
    .pc_o(pc), .sreg_o(sreg), .wreg_o(wreg), .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata),
    .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_rdata_o(bus_rdata));

  // ==========================================================
  // clock, hang guard and shared tasks
  always #20 sys_clk = ~sys_clk;

  task report_and_stop();
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // whole run needs under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task bus_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask : bus_write

  // read data stand only in the cycle after the strobe
  task read_check(input logic [5:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    @(negedge sys_clk);
    check(bus_rdata, exp);
  endtask : read_check

  // one instruction offered for one edge; ends just after the edge that takes it
  task exec(input logic [4:0] o, input logic [6:0] kk, input logic [4:0] p, input logic [2:0] b);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_op <= op_t'(o);
    instr_k <= kk;
    instr_io <= p;
    instr_bit <= b;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    @(negedge sys_clk);
  endtask : exec

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check(pc, 16'h0000);
    check(sreg, 8'h00);
    check(ready, 1'b1);
    foreach (rows[i])
    begin
      bus_write(`A_SREG, rows[i].s);
      bus_write(`A_WREG, rows[i].w);
      bus_write(`A_PCL, 8'h00);
      bus_write(`A_PCH, 8'h01);
      exec(rows[i].op, rows[i].k, 5'h00, 3'h0);
      check(pc, rows[i].epc);
      check(wreg, rows[i].ew);
      check(sreg, rows[i].es);
      check(ready, !rows[i].bub);
      @(negedge sys_clk);
      check(ready, 1'b1);
    end
    // bit ops on i/o entries 5 and 31; flags must not move
    bus_write(6'h25, 8'h5A);
    exec(5'h0B, 7'h00, 5'h05, 3'h7);
    check(ready, 1'b0);
    check(sreg, 8'h25);
    read_check(6'h25, 8'hDA);
    bus_write(6'h3F, 8'hFF);
    exec(5'h0C, 7'h00, 5'h1F, 3'h0);
    check(ready, 1'b0);
    check(sreg, 8'h25);
    read_check(6'h3F, 8'hFE);
    bus_write(6'h10, 8'hAA);
    read_check(6'h10, 8'h00);
    // reset in mid-run clears pc and the i/o registers
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check(pc, 16'h0000);
    read_check(6'h3F, 8'h00);
    // shift offered during the bubble must be taken only once, pc wraps
    bus_write(`A_SREG, 8'h01);
    bus_write(`A_WREG, 8'h81);
    bus_write(`A_PCL, 8'hFE);
    bus_write(`A_PCH, 8'hFF);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_op <= OP_BRANCH_IF_LOWER;
    instr_k <= 7'h00;
    @(posedge sys_clk);
    instr_op <= OP_SHIFT_LEFT_LOGICAL;
    @(posedge sys_clk);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    @(negedge sys_clk);
    check(pc, 16'h0000);
    check(wreg, 8'h02);
    report_and_stop();
  end
endmodule : cond_branch_shift_exec_tb
`default_nettype wire
